// file: shared/mxcmd_defines.svh
`ifndef MXCMD_DEFINES_SVH
`define MXCMD_DEFINES_SVH
`define MXC_XP_PER_UNIT      9'd25
`define MXC_COL_MAX_ALONE    9'd72
`define MXC_COL_MAX_FULL     9'd360
`define MXC_DOUT_MAX         9'd255
`define MXC_DOUT_RST         8'h00
`define MXC_SETUP_MAX        7'd100
`define MXC_STEP_RST         7'd0
`define MXC_MEMSTEP_RST      7'd1
`define MXC_SETTLE_MAX_MS    17'd65000
`define MXC_SETTLE_RST       16'h0000
`define MXC_TRIG_RST         4'd7
`define MXC_CLK_MHZ          100
`define MXC_CYC_PER_MS       (`MXC_CLK_MHZ * 1000)
`define MXC_PRIMARY_ADDR_RST 5'd18
`endif

// file: shared/mxcmd_pkg.sv
package mxcmd_pkg;
  typedef enum logic [3:0]
  {
    MXC_OP_NONE    = 4'h0,
    MXC_OP_OPEN    = 4'h1,
    MXC_OP_DOUT    = 4'h2,
    MXC_OP_CLEAR   = 4'h3,
    MXC_OP_DELETE  = 4'h4,
    MXC_OP_RESTORE = 4'h5,
    MXC_OP_SETTLE  = 4'h6,
    MXC_OP_TRIGSRC = 4'h7
  } mxcmd_op_e;

  typedef enum logic [2:0]
  {
    MXC_SRC_TALK = 3'd0,
    MXC_SRC_GET  = 3'd1,
    MXC_SRC_EXEC = 3'd2,
    MXC_SRC_EXT  = 3'd3,
    MXC_SRC_MAN  = 3'd4
  } mxcmd_src_e;

  typedef enum logic [4:0]
  {
    MXC_ST_IDLE   = 5'b00001,
    MXC_ST_SHIFT  = 5'b00010,
    MXC_ST_WIPE   = 5'b00100,
    MXC_ST_RELAY  = 5'b01000,
    MXC_ST_USER   = 5'b10000
  } mxcmd_state_e;
endpackage

// file: hdl/mxcmd_top.sv
`timescale 1ns/10ps
`include "mxcmd_defines.svh"
// Summary of operation
// - Open command: at most 25 opens and 25 closes per mainframe, else option error.
// - Column above 72 alone or 360 with four slaves gives option error.
// - Digital output takes 0..255; bit 0..7 drive lines 1..8.
// - Power-up, clears and restore set digital output to zero.
// - Digital output updates only the master's lines, never slaves.
// - Output lines are negative true: a one bit drives the line low.
// - Clear with 0 opens all relays; 1..100 clears that stored setup.
// - Delete n shifts setups n+1..100 down, clears 100, blanks display.
// - Restore does device clear first: step 0, memory step 1, then clears setups and row choices.
// - Restore reloads defaults: external falling trigger, zero settling, etc.; triggers are masked in the restore cycle only, TRIG_ENABLE is not touched.
// - Restore leaves bus address and master/slave configuration alone.
// - Settling time accepts 0..65000 ms, zero after reset, clears and restore.
// - User settling starts after card relay settling; total is their sum.
// - Trigger source decodes in pairs: talk, GET, execute, external, manual key.
// - Trigger source defaults to external pulse after reset, clears, restore.
// - Valid trigger increments step pointer saturating at 100, then loads that setup.
// - Retrigger during handling gives overrun or before-settling error by progress.
// - Talk trigger fires on first data byte request at the primary address.
// - Execute character ending the select-execute-source command counts as a trigger.
// - Manual key works when triggers enabled; front keys locked in remote except local.
// - Open command acts as the equivalent sequence of manual crosspoint selections.
// - Trigger before ready is discarded and flagged as overrun.
// - Trigger after ready but before settled is executed and flagged.
module mxcmd_top #(
  parameter int SETUPS   = 100,
  parameter int SETUP_W  = 32,
  parameter int MS_CYCLES = `MXC_CYC_PER_MS
) (
  input  wire logic                 MCLK,
  input  wire logic                 SYS_RST,
  input  wire logic                 DEV_CLEAR,
  input  wire logic                 CMD_VALID,
  input  wire mxcmd_pkg::mxcmd_op_e CMD_OP,
  input  wire logic [16:0]          CMD_PARAM,
  input  wire logic [8:0]           CMD_OPEN_COUNT,
  input  wire logic [8:0]           CMD_CLOSE_COUNT,
  input  wire logic [8:0]           CMD_MAX_COLUMN,
  input  wire logic                 CMD_EXEC,
  input  wire logic [2:0]           SLAVE_COUNT,
  input  wire logic                 TRIG_ENABLE,
  input  wire logic                 REMOTE,
  input  wire logic                 TALK_BYTE_REQ,
  input  wire logic                 GET_STROBE,
  input  wire logic                 EXT_TRIG_PIN,
  input  wire logic                 MANUAL_KEY_PIN,
  input  wire logic                 LOCAL_KEY_PIN,
  input  wire logic [15:0]          CARD_SETTLE_MS,
  output logic [7:0]                DOUT_N,
  output logic                      DOUT_OE,
  output logic [6:0]                RELAY_STEP,
  output logic [6:0]                MEMORY_STEP,
  output logic [SETUP_W-1:0]        RELAY_SETUP,
  output logic                      RELAY_LOAD,
  output logic                      OPEN_REQ,
  output logic                      ALL_OPEN,
  output logic                      ROWS_CLEAR,
  output logic                      DISPLAY_BLANK,
  output logic                      READY,
  output logic                      MATRIX_READY,
  output logic                      INVALID_OPTION_ERROR,
  output logic                      TRIG_OVERRUN,
  output logic                      TRIG_EARLY,
  output logic                      REMOTE_RELEASE,
  output logic                      FRONT_KEYS_LOCKED
);

  // Two-flop synchronisers for the panel and external pins
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  always_ff @(posedge MCLK)
  begin
    pin_s1_q <= {LOCAL_KEY_PIN, MANUAL_KEY_PIN, EXT_TRIG_PIN};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end
  logic ext_fall;
  logic man_rise;
  logic loc_rise;
  assign ext_fall = pin_s3_q[0] & ~pin_s2_q[0];
  assign man_rise = ~pin_s3_q[1] & pin_s2_q[1];
  assign loc_rise = ~pin_s3_q[2] & pin_s2_q[2];

  function automatic logic [2:0] src_decode(input logic [16:0] n);
    src_decode = 3'(n[3:1]);
  endfunction

  logic [SETUP_W-1:0] mem_q [1:SETUPS];
  logic [7:0]         dout_q;
  logic [15:0]        settle_q;
  logic [2:0]         src_q;
  logic [6:0]         step_q;
  logic [6:0]         mstep_q;
  logic [6:0]         shift_idx_q;
  logic [16:0]        ms_cnt_q;
  logic [31:0]        cyc_q;
  logic               err_q;
  logic               ovr_q;
  logic               early_q;
  logic               load_q;
  logic               open_q;
  logic               allopen_q;
  logic               rows_q;
  mxcmd_pkg::mxcmd_state_e st_q;

  logic valid_op;
  logic accept;
  logic restore;
  logic clr_all;
  logic [8:0] lim;
  logic [8:0] col_max;
  always_comb
  begin
    lim     = `MXC_XP_PER_UNIT * 9'({6'd0, SLAVE_COUNT} + 9'd1);
    col_max = (SLAVE_COUNT == 3'd0) ? `MXC_COL_MAX_ALONE : `MXC_COL_MAX_FULL;
    case (CMD_OP)
      mxcmd_pkg::MXC_OP_OPEN:    valid_op = (CMD_OPEN_COUNT <= lim) && (CMD_CLOSE_COUNT <= lim)
                                             && (CMD_MAX_COLUMN <= col_max);
      mxcmd_pkg::MXC_OP_DOUT:    valid_op = CMD_PARAM <= 17'(`MXC_DOUT_MAX);
      mxcmd_pkg::MXC_OP_CLEAR:   valid_op = CMD_PARAM <= 17'(`MXC_SETUP_MAX);
      mxcmd_pkg::MXC_OP_DELETE:  valid_op = (CMD_PARAM >= 17'd1) && (CMD_PARAM <= 17'(`MXC_SETUP_MAX));
      mxcmd_pkg::MXC_OP_RESTORE: valid_op = CMD_PARAM == 17'd0;
      mxcmd_pkg::MXC_OP_SETTLE:  valid_op = CMD_PARAM <= `MXC_SETTLE_MAX_MS;
      mxcmd_pkg::MXC_OP_TRIGSRC: valid_op = CMD_PARAM <= 17'd9;
      default:                   valid_op = 1'b0;
    endcase
  end
  // Commands are held by the parser until the execute character arrives
  // Relay settling does not hold commands off; memory walks and relay loads do
  assign accept  = CMD_VALID && CMD_EXEC && valid_op && !load_q
                   && (st_q != mxcmd_pkg::MXC_ST_SHIFT) && (st_q != mxcmd_pkg::MXC_ST_WIPE);
  assign restore = accept && (CMD_OP == mxcmd_pkg::MXC_OP_RESTORE);
  // Bus address and master/slave setup live outside this block, so restore cannot disturb them
  assign clr_all = SYS_RST || DEV_CLEAR || restore;

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      err_q <= 1'b0;
    else
      err_q <= CMD_VALID && CMD_EXEC && !valid_op;
  end

  // Master's own lines only; slaves keep their outputs
  always_ff @(posedge MCLK)
  begin
    if (clr_all)
      dout_q <= `MXC_DOUT_RST;
    else if (accept && CMD_OP == mxcmd_pkg::MXC_OP_DOUT)
      dout_q <= CMD_PARAM[7:0];
  end
  // Push-pull drive with DOUT_OE always on: a one bit drives the line low, a zero bit drives it high
  assign DOUT_N  = ~dout_q;
  assign DOUT_OE = 1'b1;

  always_ff @(posedge MCLK)
  begin
    if (clr_all)
      settle_q <= `MXC_SETTLE_RST;
    else if (accept && CMD_OP == mxcmd_pkg::MXC_OP_SETTLE)
      settle_q <= CMD_PARAM[15:0];
  end

  always_ff @(posedge MCLK)
  begin
    if (clr_all)
      src_q <= src_decode(17'(`MXC_TRIG_RST));
    else if (accept && CMD_OP == mxcmd_pkg::MXC_OP_TRIGSRC)
      src_q <= src_decode(CMD_PARAM);
  end

  // Trigger qualification
  logic trig_src_hit;
  logic trig;
  always_comb
  begin
    case (src_q)
      3'(mxcmd_pkg::MXC_SRC_TALK): trig_src_hit = TALK_BYTE_REQ;
      3'(mxcmd_pkg::MXC_SRC_GET):  trig_src_hit = GET_STROBE;
      3'(mxcmd_pkg::MXC_SRC_EXEC): trig_src_hit = CMD_VALID && CMD_EXEC;
      3'(mxcmd_pkg::MXC_SRC_EXT):  trig_src_hit = ext_fall;
      default:                     trig_src_hit = 1'b0;
    endcase
  end
  assign FRONT_KEYS_LOCKED = REMOTE;
  assign REMOTE_RELEASE    = REMOTE && loc_rise;
  // The terminator of the command that selects execute triggering is itself a trigger
  logic exec_sel;
  assign exec_sel = accept && CMD_OP == mxcmd_pkg::MXC_OP_TRIGSRC
                    && src_decode(CMD_PARAM) == 3'(mxcmd_pkg::MXC_SRC_EXEC);
  assign trig = TRIG_ENABLE && !restore
                && (trig_src_hit || exec_sel || (man_rise && !REMOTE));

  logic busy;
  logic fire;
  assign busy = (st_q == mxcmd_pkg::MXC_ST_SHIFT) || (st_q == mxcmd_pkg::MXC_ST_WIPE) || load_q;
  assign fire = trig && !busy;

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      ovr_q   <= 1'b0;
      early_q <= 1'b0;
    end
    else
    begin
      ovr_q   <= trig && busy;
      early_q <= fire && !MATRIX_READY;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (clr_all)
    begin
      step_q  <= `MXC_STEP_RST;
      mstep_q <= `MXC_MEMSTEP_RST;
    end
    else if (fire && step_q != `MXC_SETUP_MAX)
      step_q  <= step_q + 7'd1;
  end

  // Relay load is registered from the same fire as the pointer update, so both change on one edge
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      load_q <= 1'b0;
    else
      load_q <= fire;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      RELAY_SETUP <= '0;
    else if (load_q)
      RELAY_SETUP <= (step_q == 7'd0) ? '0 : mem_q[int'(step_q)];
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      open_q    <= 1'b0;
      allopen_q <= 1'b0;
      rows_q    <= 1'b0;
    end
    else
    begin
      open_q    <= accept && CMD_OP == mxcmd_pkg::MXC_OP_OPEN;
      allopen_q <= clr_all || (accept && CMD_OP == mxcmd_pkg::MXC_OP_CLEAR && CMD_PARAM == 17'd0);
      rows_q    <= restore;
    end
  end

  // Delete and restore walk the memory one location a cycle to keep one write port
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      st_q        <= mxcmd_pkg::MXC_ST_IDLE;
      shift_idx_q <= 7'd1;
    end
    else if (restore)
    begin
      st_q        <= mxcmd_pkg::MXC_ST_WIPE;
      shift_idx_q <= 7'd1;
    end
    else if (accept && CMD_OP == mxcmd_pkg::MXC_OP_DELETE)
    begin
      st_q        <= mxcmd_pkg::MXC_ST_SHIFT;
      shift_idx_q <= CMD_PARAM[6:0];
    end
    else
    begin
      case (st_q)
        mxcmd_pkg::MXC_ST_IDLE:
        begin
          if (fire)
            st_q <= mxcmd_pkg::MXC_ST_RELAY;
        end
        mxcmd_pkg::MXC_ST_SHIFT:
        begin
          if (shift_idx_q == `MXC_SETUP_MAX)
            st_q <= mxcmd_pkg::MXC_ST_IDLE;
          shift_idx_q <= shift_idx_q + 7'd1;
        end
        mxcmd_pkg::MXC_ST_WIPE:
        begin
          if (shift_idx_q == `MXC_SETUP_MAX)
            st_q <= mxcmd_pkg::MXC_ST_IDLE;
          shift_idx_q <= shift_idx_q + 7'd1;
        end
        mxcmd_pkg::MXC_ST_RELAY:
        begin
          if (fire)
            st_q <= mxcmd_pkg::MXC_ST_RELAY;
          else if (ms_cnt_q >= 17'({1'b0, CARD_SETTLE_MS}))
            st_q <= mxcmd_pkg::MXC_ST_USER;
        end
        mxcmd_pkg::MXC_ST_USER:
        begin
          if (fire)
            st_q <= mxcmd_pkg::MXC_ST_RELAY;
          else if (ms_cnt_q >= 17'({1'b0, settle_q}))
            st_q <= mxcmd_pkg::MXC_ST_IDLE;
        end
        default:
          st_q <= mxcmd_pkg::MXC_ST_IDLE;
      endcase
    end
  end

  // Millisecond counter, restarted at every settling phase boundary
  logic phase_start;
  assign phase_start = fire || (st_q == mxcmd_pkg::MXC_ST_RELAY && ms_cnt_q >= 17'({1'b0, CARD_SETTLE_MS}));
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST || phase_start || st_q == mxcmd_pkg::MXC_ST_IDLE)
    begin
      cyc_q    <= 32'd0;
      ms_cnt_q <= 17'd0;
    end
    else if (cyc_q == 32'(MS_CYCLES - 1))
    begin
      cyc_q    <= 32'd0;
      ms_cnt_q <= ms_cnt_q + 17'd1;
    end
    else
      cyc_q <= cyc_q + 32'd1;
  end

  always_ff @(posedge MCLK)
  begin
    for (int i = 1; i <= SETUPS; i++)
    begin
      if (st_q == mxcmd_pkg::MXC_ST_WIPE && int'(shift_idx_q) == i)
        mem_q[i] <= '0;
      else if (st_q == mxcmd_pkg::MXC_ST_SHIFT && int'(shift_idx_q) == i)
        mem_q[i] <= (i == SETUPS) ? '0 : mem_q[(i == SETUPS) ? i : i + 1];
      else if (accept && CMD_OP == mxcmd_pkg::MXC_OP_CLEAR && int'(CMD_PARAM) == i)
        mem_q[i] <= '0;
    end
  end

  assign RELAY_STEP           = step_q;
  assign MEMORY_STEP          = mstep_q;
  assign RELAY_LOAD           = load_q;
  assign OPEN_REQ             = open_q;
  assign ALL_OPEN             = allopen_q;
  assign ROWS_CLEAR           = rows_q;
  assign DISPLAY_BLANK        = st_q == mxcmd_pkg::MXC_ST_SHIFT;
  assign READY                = !busy;
  assign MATRIX_READY         = st_q == mxcmd_pkg::MXC_ST_IDLE;
  assign INVALID_OPTION_ERROR = err_q;
  assign TRIG_OVERRUN         = ovr_q;
  assign TRIG_EARLY           = early_q;

endmodule // mxcmd_top

// file: verif/mxcmd_asserts.sv
`timescale 1ns/10ps
module mxcmd_asserts (
  input wire logic                 MCLK,
  input wire logic                 SYS_RST,
  input wire logic                 DEV_CLEAR,
  input wire logic                 CMD_VALID,
  input wire logic                 CMD_EXEC,
  input wire mxcmd_pkg::mxcmd_op_e CMD_OP,
  input wire logic [16:0]          CMD_PARAM,
  input wire logic [8:0]           CMD_OPEN_COUNT,
  input wire logic [8:0]           CMD_CLOSE_COUNT,
  input wire logic [8:0]           CMD_MAX_COLUMN,
  input wire logic [2:0]           SLAVE_COUNT,
  input wire logic                 REMOTE,
  input wire logic [7:0]           DOUT_N,
  input wire logic [6:0]           RELAY_STEP,
  input wire logic [6:0]           MEMORY_STEP,
  input wire logic                 RELAY_LOAD,
  input wire logic                 READY,
  input wire logic                 INVALID_OPTION_ERROR,
  input wire logic                 FRONT_KEYS_LOCKED
);
  logic [7:0] par_q;
  logic       go;
  always_ff @(posedge MCLK) par_q <= CMD_PARAM[7:0];
  assign go = CMD_VALID && CMD_EXEC;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_dout;   go && CMD_OP == mxcmd_pkg::MXC_OP_DOUT;    endsequence
  sequence s_open;   go && CMD_OP == mxcmd_pkg::MXC_OP_OPEN;    endsequence
  sequence s_settle; go && CMD_OP == mxcmd_pkg::MXC_OP_SETTLE;  endsequence
  sequence s_src;    go && CMD_OP == mxcmd_pkg::MXC_OP_TRIGSRC; endsequence
  sequence s_load;   ##[0:2] RELAY_LOAD;                        endsequence
  AST_DOUT_SET: assert property (s_dout ##0 CMD_PARAM <= 17'h000FF ##0 READY |=> DOUT_N == ~par_q)
    else $error("output lines differ from inverted value");
  AST_DOUT_RANGE: assert property (s_dout ##0 CMD_PARAM > 17'h000FF |=> INVALID_OPTION_ERROR && $stable(DOUT_N))
    else $error("oversized output value not refused");
  AST_DCL_DEFAULTS: assert property (DEV_CLEAR |=> DOUT_N == 8'hFF && RELAY_STEP == 7'h00 && MEMORY_STEP == 7'h01)
    else $error("device clear defaults wrong");
  AST_OPEN_LIMIT: assert property (s_open ##0 SLAVE_COUNT == 3'h0 &&
    (CMD_OPEN_COUNT > 9'h019 || CMD_CLOSE_COUNT > 9'h019) |=> INVALID_OPTION_ERROR)
    else $error("crosspoint count limit not flagged");
  AST_COL_LIMIT: assert property (s_open ##0 (SLAVE_COUNT == 3'h0 && CMD_MAX_COLUMN > 9'h048 ||
    CMD_MAX_COLUMN > 9'h168) |=> INVALID_OPTION_ERROR)
    else $error("column limit not flagged");
  AST_SETTLE_RANGE: assert property (s_settle ##0 CMD_PARAM > 17'h0FDE8 |=> INVALID_OPTION_ERROR)
    else $error("settling time above range not flagged");
  AST_SRC_RANGE: assert property (s_src ##0 CMD_PARAM > 17'h00009 |=> INVALID_OPTION_ERROR)
    else $error("trigger source code above range not flagged");
  AST_STEP_INC: assert property (RELAY_STEP > $past(RELAY_STEP) |->
    RELAY_STEP == $past(RELAY_STEP) + 7'h01 && RELAY_STEP <= 7'h64 ##0 s_load)
    else $error("step pointer advance wrong or no relay load");
  AST_KEY_LOCK: assert property (FRONT_KEYS_LOCKED == REMOTE)
    else $error("front key lock does not follow remote");
endmodule // mxcmd_asserts

bind mxcmd_top mxcmd_asserts mxcmd_asserts_i (.MCLK, .SYS_RST, .DEV_CLEAR, .CMD_VALID, .CMD_EXEC, .CMD_OP,
  .CMD_PARAM, .CMD_OPEN_COUNT, .CMD_CLOSE_COUNT, .CMD_MAX_COLUMN, .SLAVE_COUNT, .REMOTE, .DOUT_N,
  .RELAY_STEP, .MEMORY_STEP, .RELAY_LOAD, .READY, .INVALID_OPTION_ERROR, .FRONT_KEYS_LOCKED);

// file: verif/mxcmd_host.sv
`timescale 1ns/10ps
module mxcmd_host (
  input  wire logic                 MCLK,
  input  wire logic                 INVALID_OPTION_ERROR,
  output mxcmd_pkg::mxcmd_op_e      CMD_OP,
  output logic                      CMD_VALID,
  output logic                      CMD_EXEC,
  output logic [16:0]               CMD_PARAM,
  output logic [8:0]                CMD_OPEN_COUNT,
  output logic [8:0]                CMD_CLOSE_COUNT,
  output logic [8:0]                CMD_MAX_COLUMN
);
  initial
  begin
    CMD_OP = mxcmd_pkg::MXC_OP_NONE;
    CMD_VALID = 1'b0;
    CMD_EXEC = 1'b0;
    CMD_PARAM = 17'h00000;
    CMD_OPEN_COUNT = 9'h000;
    CMD_CLOSE_COUNT = 9'h000;
    CMD_MAX_COLUMN = 9'h000;
  end
  // Whole string and its terminator arrive together; fields are scrambled after so stale values never help
  task automatic send(input mxcmd_pkg::mxcmd_op_e op, input logic [16:0] p, input logic [8:0] oc,
                      input logic [8:0] cc, input logic [8:0] col, output logic err);
    @(negedge MCLK);
    CMD_OP = op;
    CMD_PARAM = p;
    CMD_OPEN_COUNT = oc;
    CMD_CLOSE_COUNT = cc;
    CMD_MAX_COLUMN = col;
    CMD_VALID = 1'b1;
    CMD_EXEC = 1'b1;
    @(negedge MCLK);
    err = INVALID_OPTION_ERROR;
    CMD_VALID = 1'b0;
    CMD_EXEC = 1'b0;
    CMD_PARAM = ~p;
    CMD_OPEN_COUNT = ~oc;
    CMD_CLOSE_COUNT = ~cc;
    CMD_MAX_COLUMN = ~col;
  endtask
endmodule // mxcmd_host

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                 MCLK;
  logic                 SYS_RST;
  logic                 DEV_CLEAR;
  logic                 TRIG_ENABLE;
  logic                 REMOTE;
  logic                 GET_STROBE;
  logic                 EXT_TRIG_PIN;
  logic                 TALK_BYTE_REQ;
  logic [2:0]           SLAVE_COUNT;
  logic                 CMD_VALID;
  logic                 CMD_EXEC;
  mxcmd_pkg::mxcmd_op_e CMD_OP;
  logic [16:0]          CMD_PARAM;
  logic [8:0]           CMD_OPEN_COUNT;
  logic [8:0]           CMD_CLOSE_COUNT;
  logic [8:0]           CMD_MAX_COLUMN;
  logic [7:0]           DOUT_N;
  logic [6:0]           RELAY_STEP;
  logic [6:0]           MEMORY_STEP;
  logic                 READY;
  logic                 ALL_OPEN;
  logic                 DISPLAY_BLANK;
  logic                 TRIG_OVERRUN;
  logic                 TRIG_EARLY;
  logic                 INVALID_OPTION_ERROR;
  logic                 err;
  int                   bad_count;
  int                   n_checks;
  // Millisecond scaled to 10 cycles so card settling stays short
  mxcmd_top #(.MS_CYCLES(10)) mxcmd_top_i (.MCLK, .SYS_RST, .DEV_CLEAR, .CMD_VALID, .CMD_OP, .CMD_PARAM,
    .CMD_OPEN_COUNT, .CMD_CLOSE_COUNT, .CMD_MAX_COLUMN, .CMD_EXEC, .SLAVE_COUNT, .TRIG_ENABLE, .REMOTE,
    .TALK_BYTE_REQ, .GET_STROBE, .EXT_TRIG_PIN, .MANUAL_KEY_PIN(1'b0), .LOCAL_KEY_PIN(1'b0),
    .CARD_SETTLE_MS(16'h0001), .DOUT_N, .DOUT_OE(), .RELAY_STEP, .MEMORY_STEP, .RELAY_SETUP(), .RELAY_LOAD(),
    .OPEN_REQ(), .ALL_OPEN, .ROWS_CLEAR(), .DISPLAY_BLANK, .READY, .MATRIX_READY(), .INVALID_OPTION_ERROR,
    .TRIG_OVERRUN, .TRIG_EARLY, .REMOTE_RELEASE(), .FRONT_KEYS_LOCKED());
  mxcmd_host mxcmd_host_i (.MCLK, .INVALID_OPTION_ERROR, .CMD_OP, .CMD_VALID, .CMD_EXEC, .CMD_PARAM,
    .CMD_OPEN_COUNT, .CMD_CLOSE_COUNT, .CMD_MAX_COLUMN);
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic cmd(input mxcmd_pkg::mxcmd_op_e op, input logic [16:0] p, input logic e);
    mxcmd_host_i.send(op, p, 9'h000, 9'h000, 9'h001, err);
    chk("option_error", err, e);
  endtask
  task automatic opn(input logic [2:0] sl, input logic [8:0] oc, input logic [8:0] cc, input logic [8:0] col,
                     input logic e);
    SLAVE_COUNT = sl;
    mxcmd_host_i.send(mxcmd_pkg::MXC_OP_OPEN, 17'h00000, oc, cc, col, err);
    chk("open_error", err, e);
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 300 && READY !== 1'b1; k++)
      @(negedge MCLK);
  endtask
  task automatic wait_step(input logic [6:0] exp);
    for (int k = 0; k < 60 && RELAY_STEP !== exp; k++)
      @(negedge MCLK);
    chk("relay_step", RELAY_STEP, exp);
  endtask
  task automatic t_dout();
    logic [16:0] v [4] = '{17'h00000, 17'h0000F, 17'h00080, 17'h000FF};
    foreach (v[i])
    begin
      cmd(mxcmd_pkg::MXC_OP_DOUT, v[i], 1'b0);
      chk("dout_lines", DOUT_N, v[i][7:0] ^ 8'hFF);
    end
    cmd(mxcmd_pkg::MXC_OP_DOUT, 17'h00100, 1'b1);
    chk("dout_kept", DOUT_N, 8'h00);
  endtask
  // A command that lands during the memory walk is dropped
  task automatic t_clear();
    cmd(mxcmd_pkg::MXC_OP_CLEAR, 17'h00000, 1'b0);
    chk("all_open", ALL_OPEN, 1'b1);
    cmd(mxcmd_pkg::MXC_OP_CLEAR, 17'h00065, 1'b1);
    cmd(mxcmd_pkg::MXC_OP_DELETE, 17'h00000, 1'b1);
    cmd(mxcmd_pkg::MXC_OP_DELETE, 17'h00032, 1'b0);
    chk("display_blank", DISPLAY_BLANK, 1'b1);
    cmd(mxcmd_pkg::MXC_OP_DOUT, 17'h0003C, 1'b0);
    chk("dout_held", DOUT_N, 8'h00);
    cyc(60);
    chk("display_back", DISPLAY_BLANK, 1'b0);
  endtask
  task automatic t_open();
    opn(3'h0, 9'h019, 9'h019, 9'h048, 1'b0);
    opn(3'h0, 9'h01A, 9'h000, 9'h001, 1'b1);
    opn(3'h0, 9'h000, 9'h01A, 9'h001, 1'b1);
    opn(3'h0, 9'h001, 9'h000, 9'h049, 1'b1);
    opn(3'h4, 9'h001, 9'h000, 9'h168, 1'b0);
    opn(3'h4, 9'h001, 9'h000, 9'h169, 1'b1);
    SLAVE_COUNT = 3'h0;
  endtask
  // Long settling is left programmed until device clear zeroes it; trigger waits follow READY, which settling never holds off
  task automatic t_settle();
    cmd(mxcmd_pkg::MXC_OP_SETTLE, 17'h0FDE9, 1'b1);
    cmd(mxcmd_pkg::MXC_OP_SETTLE, 17'h0FDE8, 1'b0);
    cmd(mxcmd_pkg::MXC_OP_DOUT, 17'h000A5, 1'b0);
    DEV_CLEAR = 1'b1;
    cyc(1);
    DEV_CLEAR = 1'b0;
    cyc(1);
    chk("dout_clear", DOUT_N, 8'hFF);
    chk("mem_step", MEMORY_STEP, 7'h01);
  endtask
  task automatic t_trig();
    wait_rdy();
    EXT_TRIG_PIN = 1'b0;
    cyc(2);
    EXT_TRIG_PIN = 1'b1;
    wait_step(7'h01);
    TRIG_ENABLE = 1'b0;
    for (int p = 0; p < 10; p++)
      cmd(mxcmd_pkg::MXC_OP_TRIGSRC, 17'(p), 1'b0);
    cmd(mxcmd_pkg::MXC_OP_TRIGSRC, 17'h0000A, 1'b1);
    cmd(mxcmd_pkg::MXC_OP_TRIGSRC, 17'h00001, 1'b0);
    TRIG_ENABLE = 1'b1;
    wait_rdy();
    TALK_BYTE_REQ = 1'b1;
    cyc(1);
    TALK_BYTE_REQ = 1'b0;
    wait_step(7'h02);
    wait_rdy();
    cmd(mxcmd_pkg::MXC_OP_TRIGSRC, 17'h00004, 1'b0);
    wait_step(7'h03);
    TRIG_ENABLE = 1'b0;
    cmd(mxcmd_pkg::MXC_OP_TRIGSRC, 17'h00002, 1'b0);
    TRIG_ENABLE = 1'b1;
    repeat (99)
    begin
      wait_rdy();
      GET_STROBE = 1'b1;
      cyc(1);
      GET_STROBE = 1'b0;
      cyc(4);
    end
    wait_step(7'h64);
    cyc(30);
    GET_STROBE = 1'b1;
    cyc(2);
    chk("trig_overrun", TRIG_OVERRUN, 1'b1);
    cyc(1);
    chk("trig_early", TRIG_EARLY, 1'b1);
    GET_STROBE = 1'b0;
    chk("step_held", RELAY_STEP, 7'h64);
  endtask
  task automatic t_restore();
    cmd(mxcmd_pkg::MXC_OP_DOUT, 17'h0000F, 1'b0);
    cmd(mxcmd_pkg::MXC_OP_RESTORE, 17'h00001, 1'b1);
    chk("dout_kept", DOUT_N, 8'hF0);
    cmd(mxcmd_pkg::MXC_OP_RESTORE, 17'h00000, 1'b0);
    cyc(200);
    chk("dout_restore", DOUT_N, 8'hFF);
    chk("step_restore", RELAY_STEP, 7'h00);
    chk("mem_restore", MEMORY_STEP, 7'h01);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    bad_count = 0;
    n_checks = 0;
    SYS_RST = 1'b1;
    DEV_CLEAR = 1'b0;
    TRIG_ENABLE = 1'b1;
    REMOTE = 1'b1;
    GET_STROBE = 1'b0;
    EXT_TRIG_PIN = 1'b1;
    TALK_BYTE_REQ = 1'b0;
    SLAVE_COUNT = 3'h0;
    cyc(7);
    SYS_RST = 1'b0;
    chk("dout_reset", DOUT_N, 8'hFF);
    t_dout();
    t_clear();
    t_open();
    t_settle();
    t_trig();
    t_restore();
    stop_test();
  end
endmodule // tb_top
